// ---- rtl/rcbp_pkg.sv ----
/*
  constants for the receive cell bus port: cell size, widths, buffer depth.
  assumes nothing of its surroundings.
*/
`default_nettype none

package rcbp_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int CELL_BYTES = 53;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CELL_LAST = 6'h34;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_FMAX_KHZ = 38880;

  // ---------------------------------------------------------------
  // reset values of the link pins
  // ---------------------------------------------------------------
  localparam logic ENB_IDLE = 1'b1;
  localparam logic OE_OFF_N = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
endpackage

`default_nettype wire

// ---- rtl/rcbp_stream_if.sv ----
/*
  byte stream carrier between the port logic and its buffer.
  assumes one producer and one consumer on the same clock.
*/
`default_nettype none

interface rcbp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  logic two; // at least two words held, read side only

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, input two, output ready);
  modport buf_in (input valid, input data, output ready);
  modport buf_out (output valid, output data, output two, input ready);
endinterface

`default_nettype wire

// ---- rtl/rcbp_fifo.sv ----
/*
  dual clock fifo with gray coded pointers.
  assumes each reset is released synchronously to its own clock.
*/
`default_nettype none

module rcbp_fifo
  import rcbp_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rd_clk,
  input wire logic rd_resetn,
  rcbp_stream_if.buf_in wr,
  rcbp_stream_if.buf_out rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rg1;
    logic [AW:0] rg2;
  } rcbp_wside_type;

  typedef struct packed {
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] wg1;
    logic [AW:0] wg2;
  } rcbp_rside_type;

  rcbp_wside_type w_q, w_d;
  rcbp_rside_type r_q, r_d;
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] rb_w, wb_r, diff_r;
  logic full, push, pop;

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // write side
  // ---------------------------------------------------------------
  assign rb_w = g2b(w_q.rg2);
  assign full = (w_q.wbin[AW] != rb_w[AW]) &&
                (w_q.wbin[AW-1:0] == rb_w[AW-1:0]);
  assign wr.ready = ~full;
  assign push = wr.valid & ~full;

  // next write state, read pointer through two flops
  always_comb begin
    w_d = w_q;
    w_d.rg1 = r_q.rgray;
    w_d.rg2 = w_q.rg1;
    if (push) begin
      w_d.wbin = w_q.wbin + 1'b1;
    end
    w_d.wgray = w_d.wbin ^ (w_d.wbin >> 1);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  // storage, written only on the write clock
  always_ff @(posedge clk) begin
    if (push) begin
      mem[w_q.wbin[AW-1:0]] <= wr.data;
    end
  end

  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  assign wb_r = g2b(r_q.wg2);
  assign diff_r = wb_r - r_q.rbin;
  assign rd.valid = (diff_r != '0);
  assign rd.two = (diff_r > {{AW{1'b0}}, 1'b1});
  assign rd.data = mem[r_q.rbin[AW-1:0]];
  assign pop = rd.valid & rd.ready;

  // next read state, write pointer through two flops
  always_comb begin
    r_d = r_q;
    r_d.wg1 = w_q.wgray;
    r_d.wg2 = r_q.wg1;
    if (pop) begin
      r_d.rbin = r_q.rbin + 1'b1;
    end
    r_d.rgray = r_d.rbin ^ (r_d.rbin >> 1);
  end

  always_ff @(posedge rd_clk or negedge rd_resetn) begin
    if (!rd_resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule // rcbp_fifo

`default_nettype wire

// ---- rtl/rcbp_port.sv ----
/*
  receive cell bus port: bytes from the core side are buffered and
  handed to the cell layer on its receive clock, slave or master mode.
  assumes cells arrive as unbroken runs of cell-size bytes on in_data,
  and that the mode, multi-port and address pins are static.
  assumes the core keeps the buffer ahead of the link, since sixteen
  bytes cannot hold a whole cell; an underrun only stalls the cell.
  assumes the link clock runs free and that resetn is held for at
  least one edge of each clock; the link half leaves reset two link
  edges after resetn rises.
*/
`default_nettype none

module rcbp_port
  import rcbp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic master_mode,
  input wire logic multi_port,
  input wire logic [ADDR_W-1:0] port_addr,
  input wire logic rx_clk,
  input wire logic [ADDR_W-1:0] rx_addr,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_parity,
  output logic rx_soc,
  output logic rx_data_oe_n,
  input wire logic rx_clav_i,
  output logic rx_clav_o,
  output logic rx_clav_oe_n,
  input wire logic rx_enb_n_i,
  output logic rx_enb_n_o,
  output logic rx_enb_oe_n
);
  typedef struct packed {
    logic master_s1;
    logic master_s2;
    logic mphy_s1;
    logic mphy_s2;
    logic [ADDR_W-1:0] addr_s1;
    logic [ADDR_W-1:0] addr_s2;
    logic sel_q;
    logic enb_n_q;
    logic [CNT_W-1:0] cnt_q;
    logic [DATA_W-1:0] data_q;
    logic par_q;
    logic soc_q;
    logic clav_q;
    logic data_oe_n_q;
    logic clav_oe_n_q;
    logic enb_oe_n_q;
  } rcbp_link_type;

  // reset image: pins idle, every output released
  localparam rcbp_link_type LINK_RESET = '{
    master_s1: 1'b0,
    master_s2: 1'b0,
    mphy_s1: 1'b0,
    mphy_s2: 1'b0,
    addr_s1: '0,
    addr_s2: '0,
    sel_q: 1'b0,
    enb_n_q: ENB_IDLE,
    cnt_q: CNT_RESET,
    data_q: DATA_RESET,
    par_q: ~(^DATA_RESET),
    soc_q: 1'b0,
    clav_q: 1'b0,
    data_oe_n_q: OE_OFF_N,
    clav_oe_n_q: OE_OFF_N,
    enb_oe_n_q: OE_OFF_N
  };

  // link state and its next value
  rcbp_link_type s_q, s_d;
  // link half reset, released on the link clock
  logic lrst_s1, lrst_n;
  // decoded mode, address hit and transfer strobe
  logic master, mphy, match, fire;

  // core side and link side of the buffer
  rcbp_stream_if #(.W(DATA_W)) wr_if ();
  rcbp_stream_if #(.W(DATA_W)) rd_if ();

  // ---------------------------------------------------------------
  // core side into the buffer
  // ---------------------------------------------------------------
  // write side of the buffer on the core clock
  assign wr_if.valid = in_valid;
  assign wr_if.data = in_data;
  assign in_ready = wr_if.ready;
  assign wr_if.two = 1'b0; // unused on the write side

  // buffer crossing into the link clock
  // gray pointers carry the counts across
  rcbp_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .rd_clk(rx_clk),
    .rd_resetn(lrst_n),
    .wr(wr_if.buf_in),
    .rd(rd_if.buf_out)
  );

  // ---------------------------------------------------------------
  // link domain reset, released on the link clock
  // ---------------------------------------------------------------
  // link clocked
  always_ff @(posedge rx_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_s1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n <= lrst_s1;
    end
  end

  // ---------------------------------------------------------------
  // link side control
  // ---------------------------------------------------------------
  // mode gating
  assign master = s_q.master_s2;
  assign mphy = s_q.mphy_s2 & ~s_q.master_s2;

  assign match = ~mphy | (rx_addr == s_q.addr_s2);

  assign fire = master ? ~s_q.enb_n_q : (~rx_enb_n_i & s_q.sel_q);
  assign rd_if.ready = fire;

  // next link state
  always_comb begin
    s_d = s_q;
    // straps through two flops
    s_d.master_s1 = master_mode;
    s_d.master_s2 = s_q.master_s1;
    s_d.mphy_s1 = multi_port;
    s_d.mphy_s2 = s_q.mphy_s1;
    s_d.addr_s1 = port_addr;
    s_d.addr_s2 = s_q.addr_s1;

    // select latched while enable is idle, or on every edge in master mode
    if (rx_enb_n_i | master) begin
      s_d.sel_q = match;
    end

    // enable driven only while far side is ready
    s_d.enb_n_q = ~(master & rx_clav_i &
                    (s_q.enb_n_q ? rd_if.valid : rd_if.two));
    // start marker lasts one transfer
    s_d.soc_q = 1'b0;
    // byte presented in the cycle after enable
    if (fire & rd_if.valid) begin
      s_d.data_q = rd_if.data;
      s_d.par_q = ~(^rd_if.data);
      s_d.soc_q = (s_q.cnt_q == CNT_RESET);
      s_d.cnt_q = (s_q.cnt_q == CELL_LAST) ? CNT_RESET :
                  s_q.cnt_q + 1'b1;
    end

    s_d.clav_q = rd_if.valid;

    s_d.clav_oe_n_q = master | ~match;
    s_d.data_oe_n_q = ~s_d.sel_q;
    s_d.enb_oe_n_q = ~master;
  end

  // ---------------------------------------------------------------
  // link state register
  // ---------------------------------------------------------------
  // no timing beyond one link period
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      s_q <= LINK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // byte lane, parity and start marker
  assign rx_data = s_q.data_q;
  assign rx_parity = s_q.par_q;
  assign rx_soc = s_q.soc_q;

  // lane enable and the two control pins
  assign rx_data_oe_n = s_q.data_oe_n_q;
  assign rx_clav_o = s_q.clav_q;
  assign rx_clav_oe_n = s_q.clav_oe_n_q;
  assign rx_enb_n_o = s_q.enb_n_q;
  assign rx_enb_oe_n = s_q.enb_oe_n_q;
endmodule // rcbp_port

`default_nettype wire

// ---- verification/rcbp_props.sv ----
/*
  link side assertions of the receive port.
  assumes a bind to rcbp_port from the bench top.
*/
`default_nettype none

module rcbp_props (
  input wire logic resetn,
  input wire logic rx_clk,
  input wire logic master_mode,
  input wire logic multi_port,
  input wire logic [4:0] port_addr,
  input wire logic [4:0] rx_addr,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  input wire logic rx_soc,
  input wire logic rx_clav_i,
  input wire logic rx_clav_oe_n,
  input wire logic rx_enb_n_i,
  input wire logic rx_enb_n_o,
  input wire logic rx_enb_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  logic ok;
  // ----
  // settle count, straps need a few edges
  // ----
  always_ff @(posedge rx_clk or negedge resetn) begin
    if (!resetn) up_q <= 3'h0;
    else if (!ok) up_q <= up_q + 3'h1;
  end
  assign ok = up_q == 3'h7;
  default clocking @(posedge rx_clk); endclocking
  default disable iff (!resetn);
  property p_par; ^{rx_data, rx_parity}; endproperty
  a_par: assert property (p_par) else $error("even parity");
  property p_soc; rx_soc |=> !rx_soc; endproperty
  a_soc: assert property (p_soc) else $error("long soc");
  property p_sen; ok && !master_mode && rx_soc |-> !$past(rx_enb_n_i);
  endproperty
  a_sen: assert property (p_sen) else $error("soc no enable");
  property p_men; ok && master_mode && rx_soc |-> !$past(rx_enb_n_o);
  endproperty
  a_men: assert property (p_men) else $error("soc no enable");
  property p_dat;
    ok && !master_mode && $changed(rx_data) |-> !$past(rx_enb_n_i);
  endproperty
  a_dat: assert property (p_dat) else $error("data moved");
  property p_ref; ok && master_mode && !rx_clav_i |=> rx_enb_n_o;
  endproperty
  a_ref: assert property (p_ref) else $error("enable no clav");
  property p_mst; ok |-> rx_enb_oe_n == !master_mode; endproperty
  a_mst: assert property (p_mst) else $error("enable dir");
  property p_sel;
    ok && multi_port && !master_mode && !rx_clav_oe_n
      |-> $past(rx_addr) == port_addr;
  endproperty
  a_sel: assert property (p_sel) else $error("clav unaddressed");
  property p_clv; ok && !multi_port |-> rx_clav_oe_n == master_mode;
  endproperty
  a_clv: assert property (p_clv) else $error("clav dir");
  c_sl: cover property (rx_soc && !master_mode);
  c_ms: cover property (rx_soc && master_mode);
  c_mp: cover property (!rx_clav_oe_n && multi_port);
endmodule // rcbp_props

`default_nettype wire

// ---- verification/rcbp_atm_model.sv ----
/*
  cell layer model: makes the link clock, pulls bytes and keeps them.
  assumes the bench clears q between tests.
*/
`default_nettype none

module rcbp_atm_model (
  output logic rx_clk,
  input wire logic go,
  input wire logic slow,
  input wire logic master_mode,
  input wire logic [7:0] rx_data,
  input wire logic rx_soc,
  input wire logic rx_enb_n_o,
  output logic rx_enb_n_i,
  output logic rx_clav_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q[$];
  logic took = 1'b0;
  logic ph = 1'b0;
  initial rx_clk = 1'b0;
  always #16 rx_clk = ~rx_clk;
  initial rx_enb_n_i = 1'b1;
  initial rx_clav_i = 1'b0;
  // pull, sample one cycle after enable
  always @(posedge rx_clk) begin
    if (took) q.push_back({rx_soc, rx_data});
    took = master_mode ? !rx_enb_n_o : !rx_enb_n_i;
    ph = ~ph;
    rx_enb_n_i <= master_mode | !go | (slow & ph);
    rx_clav_i <= master_mode & go & !(slow & ph);
  end
endmodule // rcbp_atm_model

`default_nettype wire

// ---- verification/rcbp_port_bench.sv ----
/*
  bench for the receive port: core writes cells, the model pulls them.
  assumes the checker and model compile first.
*/
`default_nettype none

module rcbp_port_bench;
  import rcbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, in_valid = 1'b0, master_mode = 1'b0;
  logic multi_port = 1'b0, go = 1'b0, slow = 1'b0, rx_clk;
  logic [7:0] in_data = 8'h00;
  logic [4:0] port_addr = 5'h0a, rx_addr = 5'h0a;
  wire logic in_ready, rx_parity, rx_soc, rx_data_oe_n, rx_clav_i;
  wire logic rx_clav_o, rx_clav_oe_n, rx_enb_n_i, rx_enb_n_o, rx_enb_oe_n;
  wire logic [7:0] rx_data;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #5 clk = ~clk;
  rcbp_port u_dut (.clk(clk), .resetn(resetn), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .master_mode(master_mode),
    .multi_port(multi_port), .port_addr(port_addr), .rx_clk(rx_clk),
    .rx_addr(rx_addr), .rx_data(rx_data), .rx_parity(rx_parity),
    .rx_soc(rx_soc), .rx_data_oe_n(rx_data_oe_n), .rx_clav_i(rx_clav_i),
    .rx_clav_o(rx_clav_o), .rx_clav_oe_n(rx_clav_oe_n),
    .rx_enb_n_i(rx_enb_n_i), .rx_enb_n_o(rx_enb_n_o),
    .rx_enb_oe_n(rx_enb_oe_n));
  rcbp_atm_model u_atm (.rx_clk(rx_clk), .go(go), .slow(slow),
    .master_mode(master_mode), .rx_data(rx_data), .rx_soc(rx_soc),
    .rx_enb_n_o(rx_enb_n_o), .rx_enb_n_i(rx_enb_n_i),
    .rx_clav_i(rx_clav_i));
  task automatic chk(input string n, input logic [8:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // expected byte i of a run, soc on each cell start
  function automatic logic [8:0] bt(input int i);
    return {i % CELL_BYTES == 0, 8'(i * 29 + 1)};
  endfunction
  task automatic rst(input logic m, mp);
    @(negedge clk);
    resetn = 1'b0;
    master_mode = m;
    multi_port = mp;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(posedge rx_clk);
    @(negedge clk);
    chk("enb_oe", {8'h00, rx_enb_oe_n}, {8'h00, !m});
  endtask
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      in_valid = 1'b1;
      in_data = 8'(i * 29 + 1);
      while (in_ready !== 1'b1) @(negedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask
  // fill until refused, then let the model drain the run
  task automatic run(input string n, input int cnt, input logic sl,
                     input logic [4:0] a0);
    slow = sl;
    rx_addr = a0;
    u_atm.q.delete();
    fork
      send(cnt);
    join_none
    repeat (40) @(negedge clk);
    chk("full", {8'h00, in_ready}, 9'h000);
    if (!master_mode) chk("clav", {8'h00, rx_clav_o}, 9'h001);
    if (a0 != 5'h0a && !master_mode) begin
      go = 1'b1;
      repeat (20) @(negedge clk);
      chk("data_oe", {8'h00, rx_data_oe_n}, 9'h001);
      chk("clav_oe", {8'h00, rx_clav_oe_n}, 9'h001);
      go = 1'b0;
      repeat (10) @(negedge clk);
      rx_addr = 5'h0a;
      u_atm.q.delete();
    end
    go = 1'b1;
    for (int k = 0; k < 9000 && u_atm.q.size() < cnt; k++) @(negedge clk);
    go = 1'b0;
    chk("count", 9'(u_atm.q.size()), 9'(cnt));
    for (int i = 0; i < cnt; i++) chk(n, u_atm.q[i], bt(i));
    chk("parity", {8'h00, ^{rx_data, rx_parity}}, 9'h001);
    repeat (12) @(negedge clk);
    if (!master_mode) chk("empty", {8'h00, rx_clav_o}, 9'h000);
  endtask
  task automatic t_slave();
    rst(1'b0, 1'b0);
    run("slave", 106, 1'b0, 5'h0a);
    run("slave_slow", 53, 1'b1, 5'h0a);
    $display("slave test done");
  endtask
  task automatic t_master();
    rst(1'b1, 1'b0);
    run("master", 53, 1'b0, 5'h0a);
    run("master_slow", 53, 1'b1, 5'h0a);
    $display("master test done");
  endtask
  // multi-port strap ignored in master mode, any address passes
  task automatic t_mixed();
    rst(1'b1, 1'b1);
    run("mixed", 53, 1'b0, 5'h03);
    chk("mixed_data_oe", {8'h00, rx_data_oe_n}, 9'h000);
    chk("mixed_clav_oe", {8'h00, rx_clav_oe_n}, 9'h001);
    $display("mixed test done");
  endtask
  task automatic t_multi();
    rst(1'b0, 1'b1);
    run("multi", 53, 1'b0, 5'h03);
    chk("data_oe", {8'h00, rx_data_oe_n}, 9'h000);
    $display("multi test done");
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    t_slave();
    t_master();
    t_mixed();
    t_multi();
    close_out();
  end
endmodule // rcbp_port_bench

bind rcbp_port rcbp_props u_props (.resetn(resetn), .rx_clk(rx_clk),
  .master_mode(master_mode), .multi_port(multi_port),
  .port_addr(port_addr), .rx_addr(rx_addr), .rx_data(rx_data),
  .rx_parity(rx_parity), .rx_soc(rx_soc), .rx_clav_i(rx_clav_i),
  .rx_clav_oe_n(rx_clav_oe_n), .rx_enb_n_i(rx_enb_n_i),
  .rx_enb_n_o(rx_enb_n_o), .rx_enb_oe_n(rx_enb_oe_n));

`default_nettype wire
